//--- logic/irq_status.sv
// Sticky interrupt status with mask and clear-on-read
`timescale 1ns/1ps
module irq_status
(
  input  wire logic                                 i_sys_clk,
  input  wire logic                                 i_nrst,
  input  wire logic [parallel_port_pkg::IRQ_WIDTH-1:0] i_event,
  input  wire logic                                 i_sts_rd_clr,
  input  wire logic                                 i_mask_we,
  input  wire logic [parallel_port_pkg::IRQ_WIDTH-1:0] i_mask_wdata,
  output logic      [parallel_port_pkg::IRQ_WIDTH-1:0] o_status,
  output logic      [parallel_port_pkg::IRQ_WIDTH-1:0] o_mask,
  output logic                                      o_irq
);

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_status <= '0;
    else if (i_sts_rd_clr)
      o_status <= i_event;
    else
      o_status <= o_status | i_event;
  end

  // Mask written by software
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_mask <= '0;
    else if (i_mask_we)
      o_mask <= i_mask_wdata;
  end

  // Level output, registered
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_irq <= 1'b0;
    else
      o_irq <= |(o_status & o_mask);
  end

endmodule

//--- logic/level_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module level_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

//--- logic/parallel_port_pkg.sv
// Shared constants and types of the parallel port register core
package parallel_port_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [3:0] IDX_DATA     = 4'h0;
  localparam logic [3:0] IDX_STATUS   = 4'h1;
  localparam logic [3:0] IDX_CONTROL  = 4'h2;
  localparam logic [3:0] IDX_EPP_ADDR = 4'h3;
  localparam logic [3:0] IDX_EPP_D0   = 4'h4;
  localparam logic [3:0] IDX_EPP_D3   = 4'h7;
  localparam logic [3:0] IDX_MODE     = 4'h8;
  localparam logic [3:0] IDX_IRQ_STS  = 4'h9;
  localparam logic [3:0] IDX_IRQ_MASK = 4'ha;

  // Status register bit positions
  localparam int STS_CYCLE_TIMEOUT_FLAG   = 0;
  localparam int STS_FAULT   = 3;
  localparam int STS_ONLINE  = 4;
  localparam int STS_PAPER   = 5;
  localparam int STS_ACCEPT  = 6;
  localparam int STS_READY   = 7;

  // Control register bit positions
  localparam int CTL_STROBE  = 0;
  localparam int CTL_LFEED   = 1;
  localparam int CTL_INIT    = 2;
  localparam int CTL_SELECT  = 3;
  localparam int CTL_INTERRUPT_ENABLE_CTL    = 4;
  localparam int CTL_DIR     = 5;
  localparam int CTL_WIDTH   = 6;

  // Interrupt status / mask bit positions
  localparam int IRQ_CYCLE_TIMEOUT_FLAG   = 0;
  localparam int IRQ_ACK     = 1;
  localparam int IRQ_WIDTH   = 2;

  // Reset values
  localparam logic [7:0]           DATA_RESET = 8'h00;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET  = 6'h00;

  // Operating modes held in the mode register
  localparam logic [1:0] MODE_STD   = 2'h0;
  localparam logic [1:0] MODE_BIDIR = 2'h1;
  localparam logic [1:0] MODE_EPP   = 2'h2;
  localparam logic [1:0] MODE_ECP   = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // EPP watchdog: 10 us at a 50 ns clock
  localparam int         EPP_TIMEOUT_NS = 10000;
  localparam int         CLK_PERIOD_NS  = 50;
  localparam logic [7:0] EPP_TMO_CYCLES =
    8'(EPP_TIMEOUT_NS / CLK_PERIOD_NS);

  // Bus answer sequencer
  typedef enum logic [1:0]
  {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

//--- logic/parallel_port_register_core.sv
// Parallel port register core behind an Avalon-MM slave
//
// Summary of operation
// - Decode data, status, control, EPP address, EPP data
// - Data, control RW; status writable in EPP only
// - EPP registers respond only in EPP mode
// - Reset clears data latch; lines driven low
// - Written data byte appears uninverted on lines
// - Data read returns live line levels
// - Status value frozen during the read cycle
// - Status bit 0 flags EPP 10 us time-out
// - Time-out cleared by reset or writing one
// - Status bits 1 and 2 read zero
// - Status bit 3 returns live fault input
// - Control bits 0-5 stored; 6, 7 read zero
// - Standard, bidirectional, EPP and ECP modes
// - Status 4-6 direct inputs, bit 7 inverted busy
// - Control bit 0 inverted onto strobe output
`timescale 1ns/1ps
module parallel_port_register_core
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // Avalon-MM slave, byte address
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_irq,
  // Parallel data lines, two-way
  input  wire logic [7:0]  i_parallel_data_lines,
  output logic      [7:0]  o_parallel_data_lines,
  output logic             o_parallel_data_oe,
  // Printer status inputs, asynchronous
  input  wire logic        i_printer_fault_in,
  input  wire logic        i_printer_online_in,
  input  wire logic        i_paper_out_in,
  input  wire logic        i_char_accepted_in,
  input  wire logic        i_printer_busy_in,
  // Printer control outputs
  output logic             o_strobe_out_n,
  output logic             o_line_feed_ctl_n,
  output logic             o_printer_init_ctl_n,
  output logic             o_select_request_ctl_n,
  // EPP cycle sequencer hooks, same clock
  input  wire logic        i_epp_cycle_active,
  output logic             o_epp_cycle_start,
  output logic             o_epp_cycle_is_addr,
  output logic             o_epp_cycle_abort
);

  // Bus sequencing
  parallel_port_pkg::bus_state_t bus_state_q;
  logic       bus_req;
  logic       bus_done;
  logic       wr_done;
  logic       rd_done;
  logic       lane0_we;
  logic [3:0] reg_idx;
  logic [7:0] wr_byte;
  logic [7:0] rd_mux;

  // Register state
  logic [7:0]  data_q;
  logic [parallel_port_pkg::CTL_WIDTH-1:0] ctl_q;
  logic [1:0]  mode_q;
  logic        cycle_timeout_flag_q;
  logic [7:0]  wdog_cnt_q;
  logic        tmo_evt;
  logic        epp_mode;

  // Synchronised pins
  logic [7:0]  pd_sync;
  logic [4:0]  sts_async;
  logic [4:0]  sts_sync;
  logic        fault_s;
  logic        online_s;
  logic        paper_s;
  logic        accept_s;
  logic        busy_s;
  logic        accept_prev_q;
  logic        accept_rise;
  logic [7:0]  status_val;

  // Interrupt block
  logic [parallel_port_pkg::IRQ_WIDTH-1:0] irq_evt;
  logic [parallel_port_pkg::IRQ_WIDTH-1:0] irq_sts;
  logic [parallel_port_pkg::IRQ_WIDTH-1:0] irq_mask;

  // Index lies in the EPP-only window 3..7
  function automatic logic is_epp_idx(input logic [3:0] idx);
    is_epp_idx = (idx >= parallel_port_pkg::IDX_EPP_ADDR) &&
                 (idx <= parallel_port_pkg::IDX_EPP_D3);
  endfunction

  // Write strobe for one register index
  function automatic logic wr_hit(input logic [3:0] idx,
                                  input logic [3:0] want,
                                  input logic       we);
    wr_hit = we && (idx == want);
  endfunction

  assign reg_idx  = i_avs_address[5:2];
  assign wr_byte  = i_avs_writedata[7:0];
  assign bus_req  = i_avs_read | i_avs_write;
  assign bus_done = (bus_state_q == parallel_port_pkg::BUS_ANSWER);
  assign wr_done  = bus_done & i_avs_write;
  assign rd_done  = bus_done & i_avs_read;
  assign lane0_we = wr_done & i_avs_byteenable[0];
  assign epp_mode = (mode_q == parallel_port_pkg::MODE_EPP);

  // Pin inputs pass two flops before any use
  assign sts_async = {i_printer_busy_in, i_char_accepted_in,
                      i_paper_out_in, i_printer_online_in,
                      i_printer_fault_in};

  level_sync #(.WIDTH(8)) u_pd_sync
  (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   (i_parallel_data_lines),
    .o_sync    (pd_sync)
  );

  level_sync #(.WIDTH(5)) u_sts_sync
  (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   (sts_async),
    .o_sync    (sts_sync)
  );

  assign fault_s  = sts_sync[0];
  assign online_s = sts_sync[1];
  assign paper_s  = sts_sync[2];
  assign accept_s = sts_sync[3];
  assign busy_s   = sts_sync[4];

  // Status byte as seen by software
  always_comb
  begin
    status_val = 8'h00;
    status_val[parallel_port_pkg::STS_CYCLE_TIMEOUT_FLAG] =
      cycle_timeout_flag_q & epp_mode;
    status_val[parallel_port_pkg::STS_FAULT]  = fault_s;
    status_val[parallel_port_pkg::STS_ONLINE] = online_s;
    status_val[parallel_port_pkg::STS_PAPER]  = paper_s;
    status_val[parallel_port_pkg::STS_ACCEPT] = accept_s;
    status_val[parallel_port_pkg::STS_READY]  = ~busy_s;
  end

  // Read data selection
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_idx)
      parallel_port_pkg::IDX_DATA:
        rd_mux = pd_sync;
      parallel_port_pkg::IDX_STATUS:
        rd_mux = status_val;
      parallel_port_pkg::IDX_CONTROL:
        rd_mux = {2'b00, ctl_q};
      parallel_port_pkg::IDX_MODE:
        rd_mux = {6'h00, mode_q};
      parallel_port_pkg::IDX_IRQ_STS:
        rd_mux = {6'h00, irq_sts};
      parallel_port_pkg::IDX_IRQ_MASK:
        rd_mux = {6'h00, irq_mask};
      default:
      begin
        // Outside EPP the EPP window reads zero
        if (is_epp_idx(reg_idx) && epp_mode)
          rd_mux = pd_sync;
        else
          rd_mux = 8'h00;
      end
    endcase
  end

  // Answer one cycle after the request; read data is captured
  // then and held, so status cannot move under the read
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bus_state_q       <= parallel_port_pkg::BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      case (bus_state_q)
        parallel_port_pkg::BUS_IDLE:
        begin
          if (bus_req)
          begin
            bus_state_q       <= parallel_port_pkg::BUS_ANSWER;
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= i_avs_read ?
                                 {24'h00_0000, rd_mux} :
                                 32'h0000_0000;
          end
        end
        parallel_port_pkg::BUS_ANSWER:
        begin
          bus_state_q       <= parallel_port_pkg::BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state_q       <= parallel_port_pkg::BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Data latch; EPP register writes also place their byte
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      data_q <= parallel_port_pkg::DATA_RESET;
    else if (wr_hit(reg_idx, parallel_port_pkg::IDX_DATA,
                    lane0_we))
      data_q <= wr_byte;
    else if (lane0_we && is_epp_idx(reg_idx) && epp_mode)
      data_q <= wr_byte;
  end

  // Control register, six stored bits
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ctl_q <= parallel_port_pkg::CTL_RESET;
    else if (wr_hit(reg_idx, parallel_port_pkg::IDX_CONTROL,
                    lane0_we))
      ctl_q <= wr_byte[parallel_port_pkg::CTL_WIDTH-1:0];
  end

  // Mode selection; a change can move the data-line output enable
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      mode_q <= parallel_port_pkg::MODE_RESET;
    else if (wr_hit(reg_idx, parallel_port_pkg::IDX_MODE,
                    lane0_we))
      mode_q <= wr_byte[1:0];
  end

  // Watchdog counts an active EPP cycle; saturates so it
  // fires only once per cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      wdog_cnt_q <= 8'h00;
    else if (!i_epp_cycle_active)
      wdog_cnt_q <= 8'h00;
    else if (wdog_cnt_q != parallel_port_pkg::EPP_TMO_CYCLES)
      wdog_cnt_q <= wdog_cnt_q + 8'h01;
  end

  assign tmo_evt = i_epp_cycle_active &&
    (wdog_cnt_q == parallel_port_pkg::EPP_TMO_CYCLES - 8'h01);

  // Time-out flag; a new time-out beats a clear
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cycle_timeout_flag_q <= 1'b0;
    else if (tmo_evt)
      cycle_timeout_flag_q <= 1'b1;
    else if (epp_mode &&
             wr_hit(reg_idx, parallel_port_pkg::IDX_STATUS,
                    lane0_we) &&
             wr_byte[parallel_port_pkg::STS_CYCLE_TIMEOUT_FLAG])
      cycle_timeout_flag_q <= 1'b0;
  end

  // Sequencer hooks: start pulse for EPP writes, abort pulse
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_epp_cycle_start   <= 1'b0;
      o_epp_cycle_is_addr <= 1'b0;
      o_epp_cycle_abort   <= 1'b0;
    end
    else
    begin
      o_epp_cycle_start <= lane0_we && epp_mode &&
                           is_epp_idx(reg_idx);
      if (lane0_we && epp_mode && is_epp_idx(reg_idx))
        o_epp_cycle_is_addr <=
          (reg_idx == parallel_port_pkg::IDX_EPP_ADDR);
      o_epp_cycle_abort <= tmo_evt;
    end
  end

  // Acknowledge rising edge raises an interrupt when enabled
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      accept_prev_q <= 1'b0;
    else
      accept_prev_q <= accept_s;
  end

  assign accept_rise = accept_s & ~accept_prev_q;

  always_comb
  begin
    irq_evt = '0;
    irq_evt[parallel_port_pkg::IRQ_CYCLE_TIMEOUT_FLAG] = tmo_evt;
    irq_evt[parallel_port_pkg::IRQ_ACK]   =
      accept_rise & ctl_q[parallel_port_pkg::CTL_INTERRUPT_ENABLE_CTL];
  end

  irq_status u_irq
  (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .i_event      (irq_evt),
    .i_sts_rd_clr (rd_done &&
                   (reg_idx == parallel_port_pkg::IDX_IRQ_STS)),
    .i_mask_we    (wr_hit(reg_idx, parallel_port_pkg::IDX_IRQ_MASK,
                          lane0_we)),
    .i_mask_wdata (wr_byte[parallel_port_pkg::IRQ_WIDTH-1:0]),
    .o_status     (irq_sts),
    .o_mask       (irq_mask),
    .o_irq        (o_irq)
  );

  // Pin drivers, one cycle behind the registers
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_parallel_data_lines  <= 8'h00;
      o_parallel_data_oe     <= 1'b1;
      o_strobe_out_n         <= 1'b1;
      o_line_feed_ctl_n      <= 1'b1;
      o_printer_init_ctl_n   <= 1'b0;
      o_select_request_ctl_n <= 1'b1;
    end
    else
    begin
      o_parallel_data_lines <= data_q;
      // Standard mode always drives; others follow direction
      o_parallel_data_oe <=
        (mode_q == parallel_port_pkg::MODE_STD) ||
        !ctl_q[parallel_port_pkg::CTL_DIR];
      o_strobe_out_n <=
        ~ctl_q[parallel_port_pkg::CTL_STROBE];
      o_line_feed_ctl_n <=
        ~ctl_q[parallel_port_pkg::CTL_LFEED];
      o_printer_init_ctl_n <=
        ctl_q[parallel_port_pkg::CTL_INIT];
      o_select_request_ctl_n <=
        ~ctl_q[parallel_port_pkg::CTL_SELECT];
    end
  end

endmodule

//--- verif/parallel_port_register_core_checker.sv
// Bus and pin checks of the parallel port register core
`timescale 1ns/1ps
module parallel_port_register_core_checker
(
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [7:0]  o_parallel_data_lines,
  input wire logic        o_parallel_data_oe,
  input wire logic        o_strobe_out_n,
  input wire logic        o_printer_init_ctl_n,
  input wire logic        i_epp_cycle_active,
  input wire logic        o_epp_cycle_start,
  input wire logic        o_epp_cycle_abort
);
  logic [8:0] act_q;
  logic       wtk;
  logic       rtk;
  logic [3:0] idx;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Transfer completing at this edge
  assign idx = i_avs_address[5:2];
  assign wtk = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign rtk = i_avs_read && !o_avs_waitrequest;
  // Saturating count of busy sequencer cycles
  always_ff @(posedge i_sys_clk or negedge i_nrst)
    if (!i_nrst) act_q <= 9'h000;
    else if (!i_epp_cycle_active) act_q <= 9'h000;
    else if (act_q != 9'h1ff) act_q <= act_q + 9'h001;
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_answer;
    s_taken |=> s_answer;
  endproperty
  property p_rd_hold;
    rtk |=> $stable(o_avs_readdata);
  endproperty
  property p_bits12;
    rtk && idx == 4'h1 |-> o_avs_readdata[2:1] == 2'h0;
  endproperty
  property p_reset;
    $rose(i_nrst) |-> o_parallel_data_lines == 8'h00 && o_parallel_data_oe;
  endproperty
  // Register loads at the answer edge, its pin one edge later
  property p_data;
    wtk && idx == 4'h0 |-> ##2
      o_parallel_data_lines == $past(i_avs_writedata[7:0], 2);
  endproperty
  property p_strobe;
    wtk && idx == 4'h2 |-> ##2
      o_strobe_out_n == !$past(i_avs_writedata[0], 2);
  endproperty
  property p_init;
    wtk && idx == 4'h2 |-> ##2
      o_printer_init_ctl_n == $past(i_avs_writedata[2], 2);
  endproperty
  property p_epp_gate;
    o_epp_cycle_start |-> $past(wtk && idx >= 4'h3 && idx <= 4'h7);
  endproperty
  property p_abort;
    o_epp_cycle_abort |-> act_q == 9'h0c8 || act_q == 9'h0c9;
  endproperty
  property p_abort_due;
    i_epp_cycle_active && act_q == 9'h0c7 |-> ##[1:2] o_epp_cycle_abort;
  endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  a_rd_hold: assert property (p_rd_hold) else $error("read moved");
  a_bits12: assert property (p_bits12) else $error("bits 1-2 set");
  a_reset: assert property (p_reset) else $error("reset lines");
  a_data: assert property (p_data) else $error("data lines");
  a_strobe: assert property (p_strobe) else $error("strobe pin");
  a_init: assert property (p_init) else $error("init pin");
  a_epp_gate: assert property (p_epp_gate) else $error("stray cycle");
  a_abort: assert property (p_abort) else $error("abort time");
  a_abort_due: assert property (p_abort_due) else $error("no abort");
endmodule
bind parallel_port_register_core parallel_port_register_core_checker
  checker_i (.i_sys_clk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .o_parallel_data_lines, .o_parallel_data_oe, .o_strobe_out_n,
  .o_printer_init_ctl_n, .i_epp_cycle_active, .o_epp_cycle_start,
  .o_epp_cycle_abort);

//--- verif/parallel_port_register_core_tb.sv
// Self-checking bench of the parallel port register core
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module parallel_port_register_core_tb;
  logic        i_sys_clk, i_nrst, i_avs_read, i_avs_write, slow;
  logic        o_avs_waitrequest, o_irq, o_parallel_data_oe, wr_s;
  logic        o_strobe_out_n, o_printer_init_ctl_n, o_epp_cycle_is_addr;
  logic        i_printer_fault_in, i_printer_online_in, i_paper_out_in;
  logic        i_char_accepted_in, i_printer_busy_in, i_epp_cycle_active;
  logic [5:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd_s;
  logic [3:0]  i_avs_byteenable, bev;
  logic [7:0]  o_parallel_data_lines, i_parallel_data_lines, prt, reply, rd;
  logic [2:0]  cond;
  logic [14:0] pin_h;
  logic        o_line_feed_ctl_n, o_select_request_ctl_n;
  int          err_count, cmp_count, cyc, data_m, ctl_m, mode_m, tmo_m;
  int          irqs_m, irqm_m;
  int unsigned seed;
  // Wire level: host drives while enabled, else the printer
  assign i_parallel_data_lines = o_parallel_data_oe ? o_parallel_data_lines
                                                    : prt;
  parallel_port_register_core parallel_port_register_core_i (.i_sys_clk,
    .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_irq,
    .i_parallel_data_lines, .o_parallel_data_lines, .o_parallel_data_oe,
    .i_printer_fault_in, .i_printer_online_in, .i_paper_out_in,
    .i_char_accepted_in, .i_printer_busy_in, .o_strobe_out_n,
    .o_line_feed_ctl_n, .o_printer_init_ctl_n, .o_select_request_ctl_n,
    .i_epp_cycle_active, .o_epp_cycle_start(), .o_epp_cycle_is_addr,
    .o_epp_cycle_abort());
  printer_model printer_model_i (.i_sys_clk, .i_strobe_n(o_strobe_out_n),
    .i_init_n(o_printer_init_ctl_n), .i_slow(slow), .i_cond(cond),
    .i_reply(reply), .o_fault_n(i_printer_fault_in),
    .o_online(i_printer_online_in), .o_paper(i_paper_out_in),
    .o_ack_n(i_char_accepted_in), .o_busy(i_printer_busy_in), .o_data(prt));
  // Clock, and bus answer as it stood before each rising edge
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  always @(negedge i_sys_clk)
  begin
    wr_s = o_avs_waitrequest;
    rd_s = o_avs_readdata;
  end
  // Pin levels at the last three edges; a status answer carries the
  // oldest, since the pins pass two synchroniser stages first
  always @(posedge i_sys_clk)
    pin_h <= {pin_h[9:0], i_printer_busy_in, i_char_accepted_in,
      i_paper_out_in, i_printer_online_in, i_printer_fault_in};
  // Hang guard, far above the several hundred cycles needed
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // One bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input int a, input int d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= 6'(a * 4);
    i_avs_writedata <= 32'(d & 'hff);
    i_avs_byteenable <= bev;
    do @(posedge i_sys_clk); while (wr_s !== 1'b0 && ++n < 50);
    rd = rd_s[7:0];
    if (n >= 50) err_count++;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  // Expected read value from the bench's own register state
  function automatic logic [7:0] exp_rd(input int a);
    logic [7:0] p;
    p = (mode_m == 0 || ctl_m[5] == 0) ? 8'(data_m) : reply;
    case (a)
      0: return p;
      1: return {!pin_h[14], pin_h[13:10], 2'h0,
        1'(mode_m == 2 && tmo_m != 0)};
      2: return 8'(ctl_m);
      3, 4, 5, 6, 7: return mode_m == 2 ? p : 8'h00;
      8: return 8'(mode_m);
      9: return 8'(irqs_m);
      10: return 8'(irqm_m);
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input int a, input int d);
    bus(1'b1, a, d);
    if (bev[0])
      case (a)
        0: data_m = d & 'hff;
        1: if (mode_m == 2 && d[0]) tmo_m = 0;
        2: ctl_m = d & 'h3f;
        3, 4, 5, 6, 7: if (mode_m == 2) data_m = d & 'hff;
        8: mode_m = d & 3;
        10: irqm_m = d & 3;
        default: ;
      endcase
  endtask
  // Pins need time through the synchronisers before a read
  task automatic rdc(input int a);
    repeat (4) @(posedge i_sys_clk);
    bus(1'b0, a, 0);
    `CHK(rd, exp_rd(a))
    if (a == 9) irqs_m = 0;
  endtask
  task automatic settle();
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  initial
  begin
    {i_nrst, i_avs_read, i_avs_write, slow, i_epp_cycle_active} = 5'h00;
    {i_avs_address, i_avs_writedata, reply} = '0;
    bev = 4'h1;
    i_avs_byteenable = 4'h1;
    cond = 3'h7;
    seed = 30;
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    settle();
    `CHK(o_parallel_data_lines, 8'h00)
    `CHK(o_strobe_out_n, 1'b1)
    rdc(2);
    wr(2, 'hfe);
    settle();
    `CHK({o_line_feed_ctl_n, o_select_request_ctl_n}, 2'h0)
    rdc(2);
    repeat (4)
    begin
      wr(0, xs());
      settle();
      `CHK(o_parallel_data_lines, 8'(data_m))
      rdc(0);
    end
    wr(8, 1);
    wr(2, 'h24);
    reply <= 8'(xs());
    rdc(0);
    `CHK(o_parallel_data_oe, 1'b0)
    for (int s = 1; s >= 0; s--)
    begin
      cond <= 3'(xs());
      slow <= 1'(s);
      wr(2, 5);
      settle();
      `CHK(o_strobe_out_n, 1'b0)
      `CHK({o_line_feed_ctl_n, o_select_request_ctl_n}, 2'h3)
      rdc(1);
      wr(2, 4);
      repeat (70) @(posedge i_sys_clk);
      rdc(1);
    end
    for (int m = 3; m >= 0; m--)
    begin
      wr(8, m);
      wr(3, xs());
      settle();
      `CHK(o_parallel_data_lines, 8'(data_m))
      if (m == 2) `CHK(o_epp_cycle_is_addr, 1'b1)
      rdc(4 + m);
    end
    bev = 4'h0;
    wr(0, ~data_m);
    bev = 4'h1;
    settle();
    `CHK(o_parallel_data_lines, 8'(data_m))
    wr(8, 2);
    i_epp_cycle_active <= 1'b1;
    repeat (205) @(posedge i_sys_clk);
    i_epp_cycle_active <= 1'b0;
    tmo_m = 1;
    irqs_m = 1;
    rdc(1);
    `CHK(o_irq, 1'b0)
    wr(10, 1);
    rdc(10);
    settle();
    `CHK(o_irq, 1'b1)
    rdc(9);
    settle();
    `CHK(o_irq, 1'b0)
    wr(8, 0);
    rdc(1);
    wr(1, 1);
    wr(8, 2);
    rdc(1);
    rdc(8);
    wr(1, 0);
    rdc(1);
    wr(1, 1);
    rdc(1);
    rdc(11);
    test_done();
  end
endmodule

//--- verif/printer_model.sv
// Printer on the far side of the cable
`timescale 1ns/1ps
module printer_model
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_strobe_n,
  input  wire logic       i_init_n,
  input  wire logic       i_slow,
  input  wire logic [2:0] i_cond,
  input  wire logic [7:0] i_reply,
  output logic            o_fault_n,
  output logic            o_online,
  output logic            o_paper,
  output logic            o_ack_n,
  output logic            o_busy,
  output logic [7:0]      o_data
);
  logic strobe_q = 1'b1;
  int   cnt = 0;
  // Static conditions; reverse byte driven while host is off the lines
  assign {o_fault_n, o_online, o_paper} = i_cond;
  assign o_data = i_reply;
  // Busy on strobe, short ack near the end, slow or prompt
  always @(posedge i_sys_clk)
  begin
    strobe_q <= i_strobe_n;
    o_ack_n <= !(cnt > 0 && cnt < 4);
    if (!i_init_n)
    begin
      o_busy <= 1'b0;
      cnt <= 0;
    end
    else if (strobe_q && !i_strobe_n)
    begin
      o_busy <= 1'b1;
      cnt <= i_slow ? 60 : 6;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      o_busy <= cnt > 1;
    end
  end
endmodule
